// [logic/phie_pkg.sv]
package phie_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    // register offsets
    localparam logic [7:0] OFS_STATUS_SET = 8'h00;
    localparam logic [7:0] OFS_STATUS_CLEAR = 8'h04;
    localparam logic [7:0] OFS_ENABLE_SET = 8'h08;
    localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h0c;
    localparam logic [7:0] OFS_LINE_STATE = 8'h10;
    // field positions
    localparam int SOFT_LSB = 24;
    localparam int SOFT_MSB = 27;
    localparam int PARITY_BIT = 6;
    localparam int SYSTEM_BIT = 5;
    localparam int INIT_ABORT_BIT = 2;
    localparam int TARGET_ABORT_BIT = 1;
    localparam int WRITE_ZERO_BIT = 31;
    localparam int LINE_PIN_BIT = 0;
    localparam int LINE_PWR_LSB = 8;
    // masks and reset values
    localparam logic [31:0] DEFINED_MASK = 32'h0f00_0066;
    localparam logic [31:0] SOFT_MASK = 32'h0f00_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [1:0] PWR_D0 = 2'h0;

    function automatic logic [31:0] keepDefined(input logic [31:0] value);
        return value & DEFINED_MASK;
    endfunction
endpackage

// [logic/phie_reg_if.sv]
`timescale 1ns/1ns
interface phie_reg_if;
    logic wrStatusSet;
    logic wrStatusClear;
    logic wrEnableSet;
    logic wrEnableClear;
    logic [31:0] wrData;
    logic [31:0] statusVal;
    logic [31:0] enableVal;
    logic [31:0] lineVal;
    modport port (
        output wrStatusSet, wrStatusClear, wrEnableSet, wrEnableClear, wrData,
        input statusVal, enableVal, lineVal
    );
    modport core (
        input wrStatusSet, wrStatusClear, wrEnableSet, wrEnableClear, wrData,
        output statusVal, enableVal, lineVal
    );
endinterface

// [logic/phie_reg_port.sv]
`timescale 1ns/1ns
module phie_reg_port
    import phie_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic regReq,
    input wire logic regWrite,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    output logic [DATA_W-1:0] regRdata,
    output logic regAck,
    // core side
    phie_reg_if.port rif
);
    logic [31:0] rdata_q, rdata_d;
    logic ack_q;
    wire logic wrReq = regReq && regWrite;
    wire logic rdReq = regReq && !regWrite;
    wire logic hitStatus = (regAddr == OFS_STATUS_SET) || (regAddr == OFS_STATUS_CLEAR);

    // write strobes, bit 31 and reserved bits dropped
    assign rif.wrStatusSet = wrReq && (regAddr == OFS_STATUS_SET);
    assign rif.wrStatusClear = wrReq && (regAddr == OFS_STATUS_CLEAR);
    assign rif.wrEnableSet = wrReq && (regAddr == OFS_ENABLE_SET);
    assign rif.wrEnableClear = wrReq && (regAddr == OFS_ENABLE_CLEAR);
    assign rif.wrData = keepDefined(regWdata);

    // read selection, unmapped reads zero
    assign rdata_d = hitStatus ? rif.statusVal :
                     (regAddr == OFS_ENABLE_SET) ? rif.enableVal :
                     (regAddr == OFS_ENABLE_CLEAR) ? (rif.statusVal & rif.enableVal) :
                     (regAddr == OFS_LINE_STATE) ? rif.lineVal : 32'h0000_0000;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= regReq;
            if (rdReq) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign regRdata = rdata_q;
    assign regAck = ack_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    read_enable_set_a: assert property (rdReq && regAddr == OFS_ENABLE_SET |=> regAck && regRdata == $past(rif.enableVal))
        else $error("enable set read wrong");
    read_masked_a: assert property (rdReq && regAddr == OFS_ENABLE_CLEAR |=> regRdata == $past(rif.statusVal & rif.enableVal))
        else $error("masked pending read wrong");
    access_ack_a: assert property (regReq |=> regAck ##1 (regAck == $past(regReq)))
        else $error("access not answered");
endmodule

// [logic/phie_host_irq.sv]
`timescale 1ns/1ns
// Functional notes
// - writing one clears software interrupt status bits
// - writing bit 6 clears parity error flag
// - writing bit 5 clears system error flag
// - writing bit 2 clears initiator abort flag
// - writing bit 1 clears target abort flag
// - written zeros leave internal bits unchanged
// - enables change only via set/clear registers
// - pending enabled status in D0 drives pin low
// - pin suppressed in D1, D2, D3
// - enable set ones set enable bits
// - enable clear ones clear enable bits
// - enable set read returns enables
// - enable clear read returns masked status
// - host reaches registers through its windows
// - fixed enable layout, reserved zero, reset zero
// - status set ones set status bits
module phie_host_irq
    import phie_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic regReq,
    input wire logic regWrite,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    output logic [DATA_W-1:0] regRdata,
    output logic regAck,
    // function power state
    input wire logic [1:0] powerState,
    // error events from bus logic
    input wire logic parityErrEvt,
    input wire logic systemErrEvt,
    input wire logic initAbortEvt,
    input wire logic targetAbortEvt,
    // open-drain host interrupt pin
    input wire logic hostIrqPinIn,
    output logic hostIrqPinOut,
    output logic hostIrqPinOeN
);
    phie_reg_if rif ();

    logic [31:0] status_q, status_d;
    logic [31:0] enable_q, enable_d;
    logic irqOeN_q, irqOeN_d;
    logic pinS1_q, pinS2_q, pinS3_q;
    logic pinLevel_q;

    // register access
    phie_reg_port u_port (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .regReq(regReq),
        .regWrite(regWrite),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regRdata(regRdata),
        .regAck(regAck),
        .rif(rif)
    );

    // hardware detected events as a status vector
    wire logic [31:0] hwSet = keepDefined({
        25'h0, parityErrEvt, systemErrEvt, 2'h0,
        initAbortEvt, targetAbortEvt, 1'b0});

    wire logic [31:0] statSetVec = rif.wrStatusSet ? rif.wrData : 32'h0000_0000;
    wire logic [31:0] statClrVec = rif.wrStatusClear ? rif.wrData : 32'h0000_0000;
    wire logic [31:0] enSetVec = rif.wrEnableSet ? rif.wrData : 32'h0000_0000;
    wire logic [31:0] enClrVec = rif.wrEnableClear ? rif.wrData : 32'h0000_0000;

    // status: set wins over clear, zeros keep
    assign status_d = keepDefined((status_q & ~statClrVec) | statSetVec | hwSet);

    // enable: reached only through set and clear
    assign enable_d = keepDefined((enable_q & ~enClrVec) | enSetVec);

    // pin drive in D0 only
    wire logic inD0 = (powerState == PWR_D0);
    wire logic pendingAny = |(status_q & enable_q);
    assign irqOeN_d = !(pendingAny && inD0);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= STATUS_RESET;
            enable_q <= ENABLE_RESET;
            irqOeN_q <= 1'b1;
        end else begin
            status_q <= status_d;
            enable_q <= enable_d;
            irqOeN_q <= irqOeN_d;
        end
    end

    // pin level observer, change taken when stages two and three agree
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pinS1_q <= 1'b1;
            pinS2_q <= 1'b1;
            pinS3_q <= 1'b1;
            pinLevel_q <= 1'b1;
        end else begin
            pinS1_q <= hostIrqPinIn;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            if (pinS2_q == pinS3_q) begin
                pinLevel_q <= pinS3_q;
            end
        end
    end

    // values seen by the register port
    assign rif.statusVal = status_q;
    assign rif.enableVal = enable_q;
    assign rif.lineVal = {22'h0, powerState, 7'h0, pinLevel_q};

    assign hostIrqPinOut = 1'b0;
    assign hostIrqPinOeN = irqOeN_q;

    // named views of the flags
    wire logic [3:0] softwareIrqFlag = status_q[SOFT_MSB:SOFT_LSB];
    wire logic parityErrorFlag = status_q[PARITY_BIT];
    wire logic systemErrorFlag = status_q[SYSTEM_BIT];
    wire logic initiatorAbortFlag = status_q[INIT_ABORT_BIT];
    wire logic targetAbortFlag = status_q[TARGET_ABORT_BIT];
    wire logic parityErrorIrqEnable = enable_q[PARITY_BIT];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    soft_clear_a: assert property (rif.wrStatusClear |=> (softwareIrqFlag & $past(rif.wrData[SOFT_MSB:SOFT_LSB])) == 4'h0)
        else $error("software flag not cleared");

    parity_clear_a: assert property (rif.wrStatusClear && rif.wrData[PARITY_BIT] && !parityErrEvt |=> !parityErrorFlag)
        else $error("parity flag not cleared");

    system_clear_a: assert property (rif.wrStatusClear && rif.wrData[SYSTEM_BIT] && !systemErrEvt |=> !systemErrorFlag)
        else $error("system flag not cleared");

    init_clear_a: assert property (rif.wrStatusClear && rif.wrData[INIT_ABORT_BIT] && !initAbortEvt |=> !initiatorAbortFlag)
        else $error("initiator abort flag not cleared");

    target_clear_a: assert property (rif.wrStatusClear && rif.wrData[TARGET_ABORT_BIT] && !targetAbortEvt |=> !targetAbortFlag)
        else $error("target abort flag not cleared");

    zero_keeps_a: assert property (1'b1 |=> (($past(status_q) & ~status_q & ~$past(statClrVec)) == 32'h0) && (($past(enable_q) & ~enable_q & ~$past(enClrVec)) == 32'h0))
        else $error("bit lost without a written one");

    enable_hold_a: assert property (!rif.wrEnableSet && !rif.wrEnableClear |=> enable_q == $past(enable_q))
        else $error("enable changed without set or clear");

    pin_assert_a: assert property (pendingAny && inD0 |=> !hostIrqPinOeN ##0 !hostIrqPinOut)
        else $error("pin not driven while pending in D0");

    pin_release_a: assert property (!pendingAny || !inD0 |=> hostIrqPinOeN)
        else $error("pin driven without cause");

    pin_sleep_a: assert property (!inD0 [*2] |-> hostIrqPinOeN)
        else $error("pin driven outside D0");

    enable_set_a: assert property (rif.wrEnableSet |=> (enable_q & $past(rif.wrData)) == $past(rif.wrData))
        else $error("enable bit not set");

    enable_clear_a: assert property (rif.wrEnableClear |=> (enable_q & $past(rif.wrData)) == 32'h0)
        else $error("enable bit not cleared");

    reserved_zero_a: assert property ((enable_q & ~DEFINED_MASK) == 32'h0 && (status_q & ~DEFINED_MASK) == 32'h0)
        else $error("reserved bit set");

    status_set_a: assert property (rif.wrStatusSet |=> (status_q & $past(rif.wrData)) == $past(rif.wrData))
        else $error("status bit not set");

    event_sets_a: assert property (parityErrEvt || systemErrEvt || initAbortEvt || targetAbortEvt |=> (status_q & $past(hwSet)) == $past(hwSet))
        else $error("event did not set flag");

    flag_sticky_a: assert property (parityErrorFlag && !(rif.wrStatusClear && rif.wrData[PARITY_BIT]) |=> parityErrorFlag [*1])
        else $error("parity flag dropped");

    pin_raised_c: cover property (inD0 && hostIrqPinOeN ##1 !hostIrqPinOeN);
    masked_read_c: cover property (regReq && !regWrite && regAddr == OFS_ENABLE_CLEAR && pendingAny);
    set_beats_clear_c: cover property (rif.wrStatusClear && rif.wrData[PARITY_BIT] && parityErrEvt);
    leave_d0_c: cover property (!hostIrqPinOeN ##1 !inD0 ##1 hostIrqPinOeN);
    parity_irq_c: cover property (parityErrorIrqEnable && parityErrorFlag && inD0);
endmodule

// [tb/phie_host_model.sv]
`timescale 1ns/1ns
module phie_host_model (
    // pin side
    input wire logic sys_clk,
    input wire logic pinOut,
    input wire logic pinOeN,
    // host side
    output logic wireLevel,
    output logic irqSeen
);
    // pulled up whenever released
    assign wireLevel = pinOeN ? 1'b1 : pinOut;
    // host notices the low level and will look for the source
    always_ff @(posedge sys_clk) begin
        irqSeen <= ~wireLevel;
    end
endmodule

// [tb/test_pci_host_interrupt_status_enable.sv]
`timescale 1ns/1ns
module test_pci_host_interrupt_status_enable;
    import phie_pkg::*;
    logic sys_clk = 0, nrst, regReq, regWrite, regAck, pinOut, pinOeN, wireLevel, irqSeen;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, st, en, d;
    logic [1:0] powerState;
    logic [3:0] evt;
    logic [32:0] q[$];
    logic [32:0] note;
    int bad_count = 0, n_tests = 0, seed = 5, i;
    int bits[8] = '{1, 2, 5, 6, 24, 25, 26, 27};
    always #4 sys_clk = ~sys_clk;
    phie_host_irq u_dut (.sys_clk(sys_clk), .nrst(nrst), .regReq(regReq), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
        .powerState(powerState), .parityErrEvt(evt[3]), .systemErrEvt(evt[2]),
        .initAbortEvt(evt[1]), .targetAbortEvt(evt[0]), .hostIrqPinIn(wireLevel),
        .hostIrqPinOut(pinOut), .hostIrqPinOeN(pinOeN));
    phie_host_model u_host (.sys_clk(sys_clk), .pinOut(pinOut), .pinOeN(pinOeN),
        .wireLevel(wireLevel), .irqSeen(irqSeen));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d of %0d compares", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [31:0] expRead(input logic [7:0] a);
        case (a)
            OFS_STATUS_SET, OFS_STATUS_CLEAR: return st;
            OFS_ENABLE_SET: return en;
            OFS_ENABLE_CLEAR: return st & en;
            OFS_LINE_STATE: return {22'h0, powerState, 7'h0, wireLevel};
            default: return 32'h0;
        endcase
    endfunction
    // one access per call; caller idles to drop the request
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dv);
        logic [31:0] m;
        m = dv & DEFINED_MASK;
        regReq <= 1'b1;
        regWrite <= w;
        regAddr <= a;
        regWdata <= dv;
        if (w) begin
            case (a)
                OFS_STATUS_SET: st = st | m;
                OFS_STATUS_CLEAR: st = st & ~m;
                OFS_ENABLE_SET: en = en | m;
                OFS_ENABLE_CLEAR: en = en & ~m;
                default: ;
            endcase
        end
        q.push_back({~w, w ? 32'h0 : expRead(a)});
        @(posedge sys_clk);
    endtask
    task automatic settle();
        regReq <= 1'b0;
        evt <= 4'h0;
        repeat (5) @(posedge sys_clk);
        check({31'h0, pinOeN}, {31'h0, !(|(st & en) && powerState == PWR_D0)});
        check({31'h0, pinOut}, 32'h0);
    endtask
    always @(negedge sys_clk) begin
        if (regAck === 1'b1 && q.size() > 0) begin
            note = q.pop_front();
            if (note[32]) check(regRdata, note[31:0]);
        end
    end
    initial begin
        #(8 * 50000);
        bad_count++;
        results();
    end
    initial begin
        nrst = 0; regReq = 0; regWrite = 0; regAddr = 0; regWdata = 0;
        powerState = 0; evt = 0; st = STATUS_RESET; en = ENABLE_RESET;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 6; i++) acc(1'b0, 8'(i * 4), 32'h0);
        regReq <= 1'b0;
        evt <= 4'hf;
        st = st | 32'h0000_0066;
        @(posedge sys_clk);
        settle();
        acc(1'b0, OFS_STATUS_CLEAR, 32'h0);
        acc(1'b1, OFS_STATUS_SET, 32'h7fff_ffff);
        acc(1'b1, OFS_ENABLE_SET, 32'h7fff_ffff);
        acc(1'b0, OFS_ENABLE_SET, 32'h0);
        acc(1'b1, OFS_ENABLE_CLEAR, 32'h0);
        foreach (bits[k]) begin
            acc(1'b1, OFS_STATUS_CLEAR, 32'h1 << bits[k]);
            acc(1'b0, OFS_STATUS_CLEAR, 32'h0);
            acc(1'b0, OFS_ENABLE_CLEAR, 32'h0);
            settle();
        end
        acc(1'b1, OFS_STATUS_SET, 32'h0000_0004);
        for (i = 3; i >= 0; i--) begin
            powerState <= 2'(i);
            settle();
            acc(1'b0, OFS_LINE_STATE, 32'h0);
        end
        acc(1'b1, 8'h14, 32'h7fff_ffff);
        acc(1'b0, 8'h14, 32'h0);
        for (i = 0; i < 60; i++) begin
            d = $random(seed);
            acc(1'b1, 8'(d[1:0] * 4), d & 32'h7fff_ffff);
            acc(1'b0, OFS_ENABLE_SET, 32'h0);
            if (d[5:3] == 3'h0) powerState <= d[7:6];
            settle();
            if (irqSeen === 1'b1) acc(1'b0, OFS_ENABLE_CLEAR, 32'h0);
            acc(1'b0, OFS_LINE_STATE, 32'h0);
        end
        settle();
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        st = STATUS_RESET;
        en = ENABLE_RESET;
        @(posedge sys_clk);
        acc(1'b0, OFS_ENABLE_SET, 32'h0);
        acc(1'b0, OFS_STATUS_SET, 32'h0);
        settle();
        results();
    end
endmodule
